/* File: hdl/dtss_pkg.sv */
package dtss_pkg;

    // ********************************************************************
    // bus and field widths
    // ********************************************************************
    localparam int          DTSS_ADDR_W        = 8;
    localparam int          DTSS_DATA_W        = 32;
    localparam int          DTSS_NUM_LINES     = 128;
    localparam int          DTSS_CODE_W        = 7;
    localparam int          DTSS_SRC_ADDR_W    = 22;
    localparam int          DTSS_DST_ADDR_W    = 16;
    localparam int          DTSS_SIZE_W        = 12;

    // ********************************************************************
    // register byte offsets
    // ********************************************************************
    localparam logic [7:0]  OFS_CHAN_CONTROL0  = 8'h00;
    localparam logic [7:0]  OFS_CHAN_CONTROL1  = 8'h04;
    localparam logic [7:0]  OFS_DATA_BUFFER    = 8'h08;
    localparam logic [7:0]  OFS_SRC_START_L    = 8'h0c;
    localparam logic [7:0]  OFS_SRC_START_H    = 8'h10;
    localparam logic [7:0]  OFS_SRC_START_U    = 8'h14;
    localparam logic [7:0]  OFS_SRC_PTR_L      = 8'h18;
    localparam logic [7:0]  OFS_SRC_PTR_H      = 8'h1c;
    localparam logic [7:0]  OFS_SRC_PTR_U      = 8'h20;
    localparam logic [7:0]  OFS_SRC_SIZE_L     = 8'h24;
    localparam logic [7:0]  OFS_SRC_SIZE_H     = 8'h28;
    localparam logic [7:0]  OFS_SRC_CNT_L      = 8'h2c;
    localparam logic [7:0]  OFS_SRC_CNT_H      = 8'h30;
    localparam logic [7:0]  OFS_DST_START_L    = 8'h34;
    localparam logic [7:0]  OFS_DST_START_H    = 8'h38;
    localparam logic [7:0]  OFS_DST_PTR_L      = 8'h3c;
    localparam logic [7:0]  OFS_DST_PTR_H      = 8'h40;
    localparam logic [7:0]  OFS_DST_SIZE_L     = 8'h44;
    localparam logic [7:0]  OFS_DST_SIZE_H     = 8'h48;
    localparam logic [7:0]  OFS_DST_CNT_L      = 8'h4c;
    localparam logic [7:0]  OFS_DST_CNT_H      = 8'h50;
    localparam logic [7:0]  OFS_START_SEL      = 8'h54;
    localparam logic [7:0]  OFS_ABORT_SEL      = 8'h58;

    // ********************************************************************
    // control register 0 bit positions, and reset values for control 1, data buffer and selectors
    // ********************************************************************
    localparam int          CTRL0_EN_BIT       = 7;
    localparam int          CTRL0_SEN_BIT      = 6;
    localparam int          CTRL0_GO_BIT       = 5;
    localparam int          CTRL0_AEN_BIT      = 2;
    localparam int          CTRL0_BUSY_BIT     = 0;
    localparam logic [7:0]  RST_BYTE           = 8'h00;
    localparam logic [6:0]  RST_CODE           = 7'h00;

    // ********************************************************************
    // trigger code map: reserved and level-detected ranges
    // ********************************************************************
    localparam logic [6:0]  CODE_RSV_A         = 7'h00;
    localparam logic [6:0]  CODE_RSV_B         = 7'h24;
    localparam logic [6:0]  CODE_RSV_C         = 7'h3a;
    localparam logic [6:0]  CODE_RSV_D_LO      = 7'h3e;
    localparam logic [6:0]  CODE_RSV_D_HI      = 7'h45;
    localparam logic [6:0]  CODE_RSV_E_LO      = 7'h4c;
    localparam logic [6:0]  CODE_RSV_E_HI      = 7'h4f;
    localparam logic [6:0]  CODE_LAST_MAPPED   = 7'h51;
    localparam logic [6:0]  CODE_LVL_PIN       = 7'h07;
    localparam logic [6:0]  CODE_LVL_A_LO      = 7'h14;
    localparam logic [6:0]  CODE_LVL_A_HI      = 7'h1d;
    localparam logic [6:0]  CODE_LVL_B_LO      = 7'h2e;
    localparam logic [6:0]  CODE_LVL_B_HI      = 7'h34;

    typedef enum logic [1:0] {
        DTSS_IDLE = 2'b00,
        DTSS_BUSY = 2'b01
    } dtss_state_t;

endpackage

/* File: hdl/dtss_top.sv */
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module dtss_top
    import dtss_pkg::*;
(
    input  wire logic                                 CLOCK,
    input  wire logic                                 RESET,
    input  wire logic                                 PSEL,
    input  wire logic                                 PENABLE,
    input  wire logic                                 PWRITE,
    input  wire logic [dtss_pkg::DTSS_ADDR_W-1:0]     PADDR,
    input  wire logic [dtss_pkg::DTSS_DATA_W-1:0]     PWDATA,
    input  wire logic [3:0]                           PSTRB,
    output logic      [dtss_pkg::DTSS_DATA_W-1:0]     PRDATA,
    output logic                                      PREADY,
    output logic                                      PSLVERR,
    input  wire logic [dtss_pkg::DTSS_NUM_LINES-1:0]  REQ_LINES,
    input  wire logic                                 XFER_DONE,
    output logic                                      XFER_BUSY,
    output logic                                      START_PULSE,
    output logic                                      ABORT_PULSE
);
    import dtss_pkg::*;

    // ********************************************************************
    // state record
    // ********************************************************************
    typedef struct packed {
        dtss_state_t                 state;
        logic                        chan_en;
        logic                        start_trigger_enable;
        logic                        software_go;
        logic                        abort_trigger_enable;
        logic [7:0]                  ctrl1;
        logic [7:0]                  data_buf;
        logic [DTSS_SRC_ADDR_W-1:0]  src_start_addr;
        logic [DTSS_SRC_ADDR_W-1:0]  src_pointer;
        logic [DTSS_SIZE_W-1:0]      src_size;
        logic [DTSS_SIZE_W-1:0]      src_count;
        logic [DTSS_DST_ADDR_W-1:0]  dst_start_addr;
        logic [DTSS_DST_ADDR_W-1:0]  dst_pointer;
        logic [DTSS_SIZE_W-1:0]      dst_size;
        logic [DTSS_SIZE_W-1:0]      dst_count;
        logic [DTSS_CODE_W-1:0]      start_trigger_code;
        logic [DTSS_CODE_W-1:0]      abort_trigger_code;
        logic [DTSS_NUM_LINES-1:0]   req_prev;
        logic [DTSS_DATA_W-1:0]      rdata;
        logic                        slverr;
        logic                        start_pulse;
        logic                        abort_pulse;
    } dtss_regs_t;

    dtss_regs_t  st_ff;
    dtss_regs_t  nxt_st;

    // ********************************************************************
    // trigger decode, shared by both selectors
    // ********************************************************************
    function automatic logic code_reserved(input logic [DTSS_CODE_W-1:0] code);
        code_reserved = (code == CODE_RSV_A) || (code == CODE_RSV_B) || (code == CODE_RSV_C)
                     || ((code >= CODE_RSV_D_LO) && (code <= CODE_RSV_D_HI))
                     || ((code >= CODE_RSV_E_LO) && (code <= CODE_RSV_E_HI))
                     || (code > CODE_LAST_MAPPED);
    endfunction

    function automatic logic code_level(input logic [DTSS_CODE_W-1:0] code);
        code_level = (code == CODE_LVL_PIN)
                  || ((code >= CODE_LVL_A_LO) && (code <= CODE_LVL_A_HI))
                  || ((code >= CODE_LVL_B_LO) && (code <= CODE_LVL_B_HI));
    endfunction

    // a level source fires every cycle it is high; an edge source only once
    function automatic logic trig_hit(input logic [DTSS_CODE_W-1:0]    code,
                                      input logic [DTSS_NUM_LINES-1:0] lines,
                                      input logic [DTSS_NUM_LINES-1:0] prev);
        trig_hit = 1'b0;
        if (code_reserved(code)) begin
            trig_hit = 1'b0;
        end else if (code_level(code)) begin
            trig_hit = lines[code];
        end else begin
            trig_hit = lines[code] & ~prev[code];
        end
    endfunction

    logic  start_hit;
    logic  abort_hit;
    logic  setup_ph;
    logic  wr_en;
    logic  go_req;
    logic  do_start;
    logic  do_abort;

    assign start_hit = trig_hit(st_ff.start_trigger_code, REQ_LINES, st_ff.req_prev);
    assign abort_hit = trig_hit(st_ff.abort_trigger_code, REQ_LINES, st_ff.req_prev);
    assign setup_ph  = PSEL & ~PENABLE;
    assign wr_en     = PSEL & PENABLE & PWRITE & PSTRB[0];

    // ********************************************************************
    // next-state logic
    // ********************************************************************
    always_comb begin
        nxt_st             = st_ff;
        nxt_st.req_prev    = REQ_LINES;
        nxt_st.start_pulse = 1'b0;
        nxt_st.abort_pulse = 1'b0;
        go_req             = 1'b0;
        do_start           = 1'b0;
        do_abort           = 1'b0;

        // register writes take effect in the access phase
        if (wr_en) begin
            case (PADDR)
                OFS_CHAN_CONTROL0: begin
                    nxt_st.chan_en              = PWDATA[CTRL0_EN_BIT];
                    nxt_st.start_trigger_enable = PWDATA[CTRL0_SEN_BIT];
                    nxt_st.abort_trigger_enable = PWDATA[CTRL0_AEN_BIT];
                    go_req                      = PWDATA[CTRL0_GO_BIT];
                end
                OFS_CHAN_CONTROL1: nxt_st.ctrl1                  = PWDATA[7:0];
                OFS_DATA_BUFFER:   nxt_st.data_buf               = PWDATA[7:0];
                OFS_SRC_START_L:   nxt_st.src_start_addr[7:0]    = PWDATA[7:0];
                OFS_SRC_START_H:   nxt_st.src_start_addr[15:8]   = PWDATA[7:0];
                OFS_SRC_START_U:   nxt_st.src_start_addr[21:16]  = PWDATA[5:0];
                OFS_SRC_SIZE_L:    nxt_st.src_size[7:0]          = PWDATA[7:0];
                OFS_SRC_SIZE_H:    nxt_st.src_size[11:8]         = PWDATA[3:0];
                OFS_DST_START_L:   nxt_st.dst_start_addr[7:0]    = PWDATA[7:0];
                OFS_DST_START_H:   nxt_st.dst_start_addr[15:8]   = PWDATA[7:0];
                OFS_DST_SIZE_L:    nxt_st.dst_size[7:0]          = PWDATA[7:0];
                OFS_DST_SIZE_H:    nxt_st.dst_size[11:8]         = PWDATA[3:0];
                OFS_START_SEL:     nxt_st.start_trigger_code     = PWDATA[6:0];
                OFS_ABORT_SEL:     nxt_st.abort_trigger_code     = PWDATA[6:0];
                default: begin
                end
            endcase
        end

        // channel sequencing; abort outranks done, and is checked only while busy, so a start in idle is never blocked
        case (st_ff.state)
            DTSS_IDLE: begin
                if (st_ff.chan_en && (go_req || (st_ff.start_trigger_enable && start_hit))) begin
                    do_start = 1'b1;
                end
            end
            DTSS_BUSY: begin
                if (!st_ff.chan_en || (st_ff.abort_trigger_enable && abort_hit)) begin
                    do_abort = 1'b1;
                end else if (XFER_DONE) begin
                    nxt_st.state       = DTSS_IDLE;
                    nxt_st.software_go = 1'b0;
                end
            end
            default: begin
                nxt_st.state = DTSS_IDLE;
            end
        endcase

        if (do_start) begin
            nxt_st.state       = DTSS_BUSY;
            nxt_st.software_go = 1'b1;
            nxt_st.start_pulse = 1'b1;
            // pointers and counts reload from the programmed start values
            nxt_st.src_pointer = st_ff.src_start_addr;
            nxt_st.src_count   = st_ff.src_size;
            nxt_st.dst_pointer = st_ff.dst_start_addr;
            nxt_st.dst_count   = st_ff.dst_size;
        end
        if (do_abort) begin
            nxt_st.state       = DTSS_IDLE;
            nxt_st.software_go = 1'b0;
            // pulse on every abort, enable clear included
            nxt_st.abort_pulse = 1'b1;
        end

        // read data is captured in the setup phase so the access needs no wait
        nxt_st.rdata  = '0;
        nxt_st.slverr = 1'b0;
        if (setup_ph) begin
            case (PADDR)
                OFS_CHAN_CONTROL0: begin
                    nxt_st.rdata[CTRL0_EN_BIT]  = st_ff.chan_en;
                    nxt_st.rdata[CTRL0_SEN_BIT] = st_ff.start_trigger_enable;
                    nxt_st.rdata[CTRL0_GO_BIT]  = st_ff.software_go;
                    nxt_st.rdata[CTRL0_AEN_BIT] = st_ff.abort_trigger_enable;
                    nxt_st.rdata[CTRL0_BUSY_BIT] = (st_ff.state == DTSS_BUSY);
                end
                OFS_CHAN_CONTROL1: nxt_st.rdata[7:0] = st_ff.ctrl1;
                OFS_DATA_BUFFER:   nxt_st.rdata[7:0] = st_ff.data_buf;
                OFS_SRC_START_L:   nxt_st.rdata[7:0] = st_ff.src_start_addr[7:0];
                OFS_SRC_START_H:   nxt_st.rdata[7:0] = st_ff.src_start_addr[15:8];
                OFS_SRC_START_U:   nxt_st.rdata[5:0] = st_ff.src_start_addr[21:16];
                OFS_SRC_PTR_L:     nxt_st.rdata[7:0] = st_ff.src_pointer[7:0];
                OFS_SRC_PTR_H:     nxt_st.rdata[7:0] = st_ff.src_pointer[15:8];
                OFS_SRC_PTR_U:     nxt_st.rdata[5:0] = st_ff.src_pointer[21:16];
                OFS_SRC_SIZE_L:    nxt_st.rdata[7:0] = st_ff.src_size[7:0];
                OFS_SRC_SIZE_H:    nxt_st.rdata[3:0] = st_ff.src_size[11:8];
                OFS_SRC_CNT_L:     nxt_st.rdata[7:0] = st_ff.src_count[7:0];
                OFS_SRC_CNT_H:     nxt_st.rdata[3:0] = st_ff.src_count[11:8];
                OFS_DST_START_L:   nxt_st.rdata[7:0] = st_ff.dst_start_addr[7:0];
                OFS_DST_START_H:   nxt_st.rdata[7:0] = st_ff.dst_start_addr[15:8];
                OFS_DST_PTR_L:     nxt_st.rdata[7:0] = st_ff.dst_pointer[7:0];
                OFS_DST_PTR_H:     nxt_st.rdata[7:0] = st_ff.dst_pointer[15:8];
                OFS_DST_SIZE_L:    nxt_st.rdata[7:0] = st_ff.dst_size[7:0];
                OFS_DST_SIZE_H:    nxt_st.rdata[3:0] = st_ff.dst_size[11:8];
                OFS_DST_CNT_L:     nxt_st.rdata[7:0] = st_ff.dst_count[7:0];
                OFS_DST_CNT_H:     nxt_st.rdata[3:0] = st_ff.dst_count[11:8];
                OFS_START_SEL:     nxt_st.rdata[6:0] = st_ff.start_trigger_code;
                OFS_ABORT_SEL:     nxt_st.rdata[6:0] = st_ff.abort_trigger_code;
                default:           nxt_st.slverr     = 1'b1;
            endcase
        end else if (PSEL && PENABLE) begin
            nxt_st.rdata  = st_ff.rdata;
            nxt_st.slverr = st_ff.slverr;
        end
    end

    // ********************************************************************
    // state register
    // ********************************************************************
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            st_ff                    <= '0;
            st_ff.state              <= DTSS_IDLE;
            st_ff.ctrl1              <= RST_BYTE;
            st_ff.data_buf           <= RST_BYTE;
            st_ff.start_trigger_code <= RST_CODE;
            st_ff.abort_trigger_code <= RST_CODE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign PRDATA      = st_ff.rdata;
    assign PREADY      = 1'b1;
    assign PSLVERR     = PSEL & PENABLE & st_ff.slverr;
    assign XFER_BUSY   = (st_ff.state == DTSS_BUSY);
    assign START_PULSE = st_ff.start_pulse;
    assign ABORT_PULSE = st_ff.abort_pulse;

    // ********************************************************************
    // checks
    // ********************************************************************
    property p_abort_sel_write;
        @(posedge CLOCK) disable iff (RESET)
        (wr_en && PADDR == OFS_ABORT_SEL) |=> (st_ff.abort_trigger_code == $past(PWDATA[6:0]));
    endproperty
    a_abort_sel_write: assert property (p_abort_sel_write) else $error("abort selector write lost");

    property p_sel_top_zero;
        @(posedge CLOCK) disable iff (RESET)
        (PSEL && PENABLE && !PWRITE && (PADDR == OFS_ABORT_SEL || PADDR == OFS_START_SEL))
            |-> (PRDATA[31:7] == '0);
    endproperty
    a_sel_top_zero: assert property (p_sel_top_zero) else $error("selector top bit not zero");

    property p_same_map;
        @(posedge CLOCK) disable iff (RESET)
        (st_ff.start_trigger_code == st_ff.abort_trigger_code) |-> (start_hit == abort_hit);
    endproperty
    a_same_map: assert property (p_same_map) else $error("selectors decode differently");

    property p_reserved_silent;
        @(posedge CLOCK) disable iff (RESET)
        code_reserved(st_ff.start_trigger_code) |-> !start_hit;
    endproperty
    a_reserved_silent: assert property (p_reserved_silent) else $error("reserved code fired");

    property p_edge_once;
        @(posedge CLOCK) disable iff (RESET)
        (!code_level(st_ff.abort_trigger_code) && abort_hit) |=>
            (!abort_hit || ($past(st_ff.abort_trigger_code) != st_ff.abort_trigger_code));
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge source fired twice");

    property p_level_hold;
        @(posedge CLOCK) disable iff (RESET)
        (code_level(st_ff.start_trigger_code) && !code_reserved(st_ff.start_trigger_code)
            && REQ_LINES[st_ff.start_trigger_code]) |-> start_hit;
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level source missed");

    property p_ctrl0_layout;
        @(posedge CLOCK) disable iff (RESET)
        (setup_ph && !PWRITE && PADDR == OFS_CHAN_CONTROL0) |=>
            (PRDATA[4:3] == 2'b00 && !PRDATA[1] && PRDATA[0] == $past(XFER_BUSY)
             && PRDATA[7] == $past(st_ff.chan_en));
    endproperty
    a_ctrl0_layout: assert property (p_ctrl0_layout) else $error("control0 readback wrong");

    property p_size_high_zero;
        @(posedge CLOCK) disable iff (RESET)
        (PSEL && PENABLE && !PWRITE && (PADDR == OFS_SRC_SIZE_H || PADDR == OFS_DST_CNT_H))
            |-> (PRDATA[31:4] == '0);
    endproperty
    a_size_high_zero: assert property (p_size_high_zero) else $error("unused bits read nonzero");

    property p_start_sel_write;
        @(posedge CLOCK) disable iff (RESET)
        (wr_en && PADDR == OFS_START_SEL) |=> (st_ff.start_trigger_code == $past(PWDATA[6:0]));
    endproperty
    a_start_sel_write: assert property (p_start_sel_write) else $error("start selector write lost");

    property p_abort_stops;
        @(posedge CLOCK) disable iff (RESET)
        (XFER_BUSY && st_ff.abort_trigger_enable && abort_hit) |=> (!XFER_BUSY && ABORT_PULSE);
    endproperty
    a_abort_stops: assert property (p_abort_stops) else $error("abort did not stop transfer");

endmodule

/* File: verif/dtss_req_model.sv */
`timescale 1ns/1ps
module dtss_req_model
    import dtss_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      reset,
    input  wire logic [DTSS_CODE_W-1:0]    line_code,
    input  wire logic                      line_high,
    output logic      [DTSS_NUM_LINES-1:0] req_lines
);
    logic tog_ff;
    // line 0 and lines 82 to 127 chatter every cycle, so a decoder that lets them through shows up
    always_ff @(posedge clock) begin
        tog_ff <= reset ? 1'b0 : ~tog_ff;
    end
    always_comb begin
        req_lines = {{46{tog_ff}}, 81'h0, tog_ff};
        req_lines[line_code] = req_lines[line_code] | line_high;
    end
endmodule

/* File: verif/tb_dtss_top.sv */
`timescale 1ns/1ps
module tb_dtss_top;
    import dtss_pkg::*;
    logic         CLOCK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, XFER_DONE = 0, lvl = 0, err;
    logic [7:0]   PADDR = 0;
    logic [31:0]  PWDATA = 0, PRDATA, rd, d;
    logic [3:0]   PSTRB = 4'hf;
    logic         PREADY, PSLVERR, XFER_BUSY, START_PULSE, ABORT_PULSE;
    logic [127:0] REQ_LINES;
    logic [6:0]   code = 0, c;
    int           bad_count = 0, cmp_count = 0, seed = 83003, cyc = 0;
    logic [7:0]   ta [5] = '{OFS_SRC_SIZE_H, OFS_DST_SIZE_H, OFS_SRC_START_U, OFS_SRC_CNT_H, OFS_DST_PTR_L};
    logic [7:0]   te [5] = '{8'h0f, 8'h0f, 8'h3f, 8'h00, 8'h00};
    logic [6:0]   corner [17] = '{7, 20, 29, 30, 36, 46, 52, 53, 58, 62, 69, 76, 81, 82, 127, 0, 1};

    dtss_top dtss_top_i (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .REQ_LINES(REQ_LINES), .XFER_DONE(XFER_DONE), .XFER_BUSY(XFER_BUSY), .START_PULSE(START_PULSE),
        .ABORT_PULSE(ABORT_PULSE));
    dtss_req_model dtss_req_model_i (.clock(CLOCK), .reset(RESET), .line_code(code), .line_high(lvl),
        .req_lines(REQ_LINES));

    initial forever #25 CLOCK = ~CLOCK;

    // ****************************************************************
    // expectation helpers
    // ****************************************************************
    function automatic logic rsv(input logic [6:0] k);
        return k == 0 || k == 36 || k == 58 || (k >= 62 && k <= 69) || (k >= 76 && k <= 79) || k > 81;
    endfunction
    function automatic logic lvl_code(input logic [6:0] k);
        return k == 7 || (k >= 20 && k <= 29) || (k >= 46 && k <= 52);
    endfunction
    task automatic close_out;
        $display("counts: compared %0d mismatched %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // entered just after a rising edge; holds the request until pready is seen high,
    // then one idle edge so back-to-back calls never reassign psel in one time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLOCK);
        PENABLE <= 1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        @(posedge CLOCK);
    endtask
    task automatic edges(input int n);
        repeat (n) @(posedge CLOCK);
    endtask
    // level phase, edge phase, then abort on the same code
    task automatic trig(input logic [6:0] k);
        apb(1, OFS_START_SEL, {25'h0, k});
        code <= k;
        lvl <= 1;
        edges(2);
        apb(1, OFS_CHAN_CONTROL0, 32'hc0);
        edges(3);
        chk(XFER_BUSY, lvl_code(k) && !rsv(k), "held line start");
        lvl <= 0;
        XFER_DONE <= 1;
        edges(1);
        XFER_DONE <= 0;
        edges(1);
        lvl <= 1;
        edges(2);
        chk(START_PULSE, !rsv(k), "start pulse");
        lvl <= 0;
        apb(1, OFS_ABORT_SEL, {25'h0, k});
        apb(1, OFS_CHAN_CONTROL0, 32'h84);
        chk(XFER_BUSY, !rsv(k), "busy before abort");
        lvl <= 1;
        edges(2);
        chk(ABORT_PULSE, !rsv(k), "abort pulse");
        edges(1);
        chk(XFER_BUSY, 0, "busy after abort");
        lvl <= 0;
        apb(1, OFS_CHAN_CONTROL0, 0);
        edges(2);
    endtask

    always @(posedge CLOCK) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        edges(12);
        RESET <= 0;
        edges(1);
        apb(0, OFS_START_SEL, 0);
        chk(rd, 0, "start select reset");
        apb(0, OFS_ABORT_SEL, 0);
        chk(rd, 0, "abort select reset");
        apb(0, OFS_CHAN_CONTROL0, 0);
        chk(rd, 0, "control0 reset");
        repeat (8) begin
            d = $random(seed);
            apb(1, OFS_ABORT_SEL, d);
            apb(0, OFS_ABORT_SEL, 0);
            chk(rd, {25'h0, d[6:0]}, "abort select rw");
            apb(1, OFS_START_SEL, ~d);
            apb(0, OFS_START_SEL, 0);
            chk(rd, {25'h0, ~d[6:0]}, "start select rw");
        end
        PSTRB <= 4'h0;
        apb(1, OFS_ABORT_SEL, ~d);
        PSTRB <= 4'hf;
        apb(0, OFS_ABORT_SEL, 0);
        chk(rd, {25'h0, d[6:0]}, "strobe-less write ignored");
        $display("test selectors done");
        // go with enable not yet set must not start; bit 0 write is ignored
        apb(1, OFS_CHAN_CONTROL0, 32'hff);
        apb(0, OFS_CHAN_CONTROL0, 0);
        chk(rd, 32'hc4, "control0 layout");
        apb(1, OFS_CHAN_CONTROL0, 32'h80);
        apb(1, OFS_CHAN_CONTROL0, 32'ha0);
        apb(0, OFS_CHAN_CONTROL0, 0);
        chk(rd, 32'ha1, "go start");
        apb(1, OFS_CHAN_CONTROL0, 0);
        edges(1);
        chk(XFER_BUSY, 0, "enable clear stops");
        chk(ABORT_PULSE, 1, "enable clear pulse");
        for (int i = 0; i < 5; i++) begin
            apb(1, ta[i], 32'hff);
            apb(0, ta[i], 0);
            chk(rd, {24'h0, te[i]}, "unimplemented bits");
        end
        apb(0, 8'hfc, 0);
        chk({31'h0, err}, 1, "unmapped error");
        $display("test register map done");
        foreach (corner[i]) trig(corner[i]);
        repeat (8) begin
            d = $random(seed);
            c = d[6:0];
            trig(c);
        end
        $display("test triggers done");
        close_out();
    end
endmodule
